/* File: hw/stm_timer.sv */
`timescale 1ns/1ps
module stm_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        high_clock_tick,
  input  wire logic        time_base_tick,
  input  wire logic        external_count_clock_pin,
  input  wire logic        capture_input_pin,
  output logic             primary_output_pin,
  output logic             secondary_output_pin,
  output logic             cmp_a_irq,
  output logic             cmp_p_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0]  timer_control_zero;  // Pause, clock, on, period
  logic [7:0]  timer_control_one;   // Mode, function, output control
  logic [9:0]  count;               // Live counter
  logic [9:0]  compare_a_value;     // Active compare-A value
  logic [7:0]  hold_buf;            // Shared eight-bit holding buffer
  logic        on_prev;             // Previous module_on for edge
  logic        out_lvl;             // Output level before polarity
  logic [5:0]  div_sys;             // System clock divider
  logic [5:0]  div_h;               // High clock divider
  logic        pulse_done;          // Single pulse already fired

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire        counter_pause    = timer_control_zero[stm_pkg::pause_bit];
  wire [2:0]  count_clock_select =
    timer_control_zero[stm_pkg::cksel_hi:stm_pkg::cksel_lo];
  wire        module_on        = timer_control_zero[stm_pkg::on_bit];
  wire [2:0]  period_setting   = timer_control_zero[stm_pkg::per_hi:0];
  wire [1:0]  mode_sel         =
    timer_control_one[stm_pkg::mode_hi:stm_pkg::mode_lo];
  wire [1:0]  pin_function     =
    timer_control_one[stm_pkg::func_hi:stm_pkg::func_lo];
  wire        output_initial_level = timer_control_one[stm_pkg::oc_bit];
  wire        output_polarity  = timer_control_one[stm_pkg::pol_bit];
  wire        period_duty_swap = timer_control_one[stm_pkg::dpx_bit];
  wire        clear_source_select = timer_control_one[stm_pkg::cclr_bit];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, never errors
  wire setup_phase = psel & ~penable;
  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire rd    = acc & ~pwrite;
  wire hit_c0 = paddr == stm_pkg::ctrl0_off;
  wire hit_c1 = paddr == stm_pkg::ctrl1_off;
  wire hit_dl = paddr == stm_pkg::cnt_lo_off;
  wire hit_dh = paddr == stm_pkg::cnt_hi_off;
  wire hit_al = paddr == stm_pkg::cmp_lo_off;
  wire hit_ah = paddr == stm_pkg::cmp_hi_off;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic ext_rise;  // External clock rising edge pulse
  logic ext_fall;  // External clock falling edge pulse
  logic cap_rise;  // Capture rising edge pulse
  logic cap_fall;  // Capture falling edge pulse

  stm_edge_sync u_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (external_count_clock_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );
  stm_edge_sync u_cap (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (capture_input_pin),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tick source selection
  wire sys4_tick = div_sys[1:0] == stm_pkg::div4_last[1:0];
  wire h16_tick  = high_clock_tick & (div_h[3:0] == stm_pkg::div16_last[3:0]);
  wire h64_tick  = high_clock_tick & (div_h == stm_pkg::div64_last);
  logic sel_tick;  // Selected count tick

  always_comb begin
    unique case (count_clock_select)
      stm_pkg::ck_sys4: sel_tick = sys4_tick;
      stm_pkg::ck_sys:  sel_tick = 1'b1;
      stm_pkg::ck_h16:  sel_tick = h16_tick;
      stm_pkg::ck_h64:  sel_tick = h64_tick;
      stm_pkg::ck_tbc:  sel_tick = time_base_tick;
      stm_pkg::ck_rise: sel_tick = ext_rise;
      stm_pkg::ck_fall: sel_tick = ext_fall;
      default:          sel_tick = 1'b0;
    endcase
  end

  // Free dividers; high clock arrives as an enable pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sys <= 6'h00;
      div_h   <= 6'h00;
    end else begin
      div_sys <= div_sys + 6'h01;
      if (high_clock_tick) begin
        div_h <= div_h + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and comparators
  wire on_rise = module_on & ~on_prev;
  // count when on and not paused
  wire adv = module_on & ~counter_pause & sel_tick & ~on_rise;
  // Value the counter is about to reach; matching on it makes the
  // cleared period exactly N times 128 ticks, not one more
  wire [9:0] count_inc = count + 10'h001;
  wire p_match = adv &
    (count_inc[stm_pkg::cnt_w-1 -: stm_pkg::per_w] == period_setting) &
    (period_setting != 3'h0) &
    (count_inc[stm_pkg::cnt_w-stm_pkg::per_w-1:0] == 7'h00);
  wire a_match = adv & (count == compare_a_value);
  wire ovf = adv & (&count);
  wire pwm_like = mode_sel == stm_pkg::md_pwm;
  wire cap_mode = mode_sel == stm_pkg::md_cap;
  // clear source choice
  // In PWM the period comparator clears unless the swap bit is set
  wire clr_sel = pwm_like ? period_duty_swap : clear_source_select;
  wire auto_clr = ~cap_mode &
    (clr_sel ? a_match : (p_match | (period_setting == 3'h0 & ovf)));
  logic [9:0] next_count;  // Counter next value

  always_comb begin
    if (on_rise) begin
      next_count = stm_pkg::cnt_rst;
    end else if (auto_clr | ovf) begin
      next_count = stm_pkg::cnt_rst;
    end else if (adv) begin
      next_count = count + 10'h001;
    end else begin
      next_count = count;
    end
  end

  // Counter flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= stm_pkg::cnt_rst;
      on_prev <= 1'b0;
    end else begin
      count   <= next_count;
      on_prev <= module_on;
    end
  end

  wire cap_evt = cap_mode & module_on & (
    (pin_function == stm_pkg::fn_0 & cap_rise) |
    (pin_function == stm_pkg::fn_1 & cap_fall) |
    (pin_function == stm_pkg::fn_2 & (cap_rise | cap_fall)));

  // two interrupt events; capture reports on A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_irq <= 1'b0;
      cmp_p_irq <= 1'b0;
    end else begin
      cmp_a_irq <= cap_mode ? cap_evt : a_match;
      cmp_p_irq <= p_match | (period_setting == 3'h0 & ovf);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output waveform
  wire period_evt = period_duty_swap ? a_match :
    (p_match | (period_setting == 3'h0 & ovf));
  wire duty_evt = period_duty_swap ? p_match : a_match;
  logic next_out;  // Output next level

  always_comb begin
    next_out = out_lvl;
    if (on_rise) begin
      next_out = output_initial_level;
    end else if (mode_sel == stm_pkg::md_cmp && a_match) begin
      unique case (pin_function)
        stm_pkg::fn_0: next_out = out_lvl;
        stm_pkg::fn_1: next_out = 1'b0;
        stm_pkg::fn_2: next_out = 1'b1;
        stm_pkg::fn_3: next_out = ~out_lvl;
      endcase
    end else if (pwm_like) begin
      unique case (pin_function)
        stm_pkg::fn_0: next_out = ~output_initial_level;
        stm_pkg::fn_1: next_out = output_initial_level;
        stm_pkg::fn_2: begin
          if (period_evt) next_out = output_initial_level;
          else if (duty_evt) next_out = ~output_initial_level;
        end
        stm_pkg::fn_3: begin
          if (duty_evt && !pulse_done) next_out = ~output_initial_level;
        end
      endcase
    end
  end

  // Output level and single-pulse latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_lvl    <= 1'b0;
      pulse_done <= 1'b0;
    end else begin
      out_lvl <= next_out;
      if (on_rise) pulse_done <= 1'b0;
      else if (duty_evt) pulse_done <= 1'b1;
    end
  end

  wire inv = output_polarity & (mode_sel != stm_pkg::md_tmr);
  // Pin sharing is outside; both outputs always driven here
  assign primary_output_pin   = out_lvl ^ inv;
  assign secondary_output_pin = ~(out_lvl ^ inv);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  // low write fills buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_zero <= stm_pkg::ctrl_rst;
      timer_control_one  <= stm_pkg::ctrl_rst;
      compare_a_value    <= stm_pkg::cnt_rst;
      hold_buf           <= 8'h00;
    end else begin
      if (wr && hit_c0) timer_control_zero <= pwdata[7:0];
      if (wr && hit_c1) timer_control_one  <= pwdata[7:0];
      if (wr && hit_al) hold_buf <= pwdata[7:0];
      if (wr && hit_ah) compare_a_value <= {pwdata[1:0], hold_buf};
      if (rd && hit_dh) hold_buf <= count[7:0];
      if (rd && hit_ah) hold_buf <= compare_a_value[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_byte;  // Selected byte
  always_comb begin
    rd_byte = 8'h00;
    if (hit_c0) rd_byte = timer_control_zero;
    if (hit_c1) rd_byte = timer_control_one;
    if (hit_dl | hit_al) rd_byte = hold_buf;
    if (hit_dh) rd_byte = {6'h00, count[9:8]};
    if (hit_ah) rd_byte = {6'h00, compare_a_value[9:8]};
  end
  // Data held combinational from flop state; forced to zero in setup phase
  assign prdata = {24'h000000, rd_byte} & {32{~setup_phase}};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // switch-on clears
  a_on_clears: assert property (@(posedge pclk) disable iff (!presetn)
    on_rise |=> count == 10'h000) else $error("switch-on did not clear");
  a_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (!module_on && on_prev == 1'b0) |=> $stable(count))
    else $error("counter moved while off");
  a_pause_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_pause && !on_rise) |=> $stable(count))
    else $error("counter moved while paused");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (adv && !auto_clr && !ovf) |=> count == $past(count) + 10'h001)
    else $error("counter did not step");
  a_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (count_clock_select == 3'h5) |-> !sel_tick) else $error("tick on 101");
  a_cmp_commit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_ah) |=> compare_a_value[7:0] == $past(hold_buf))
    else $error("buffer not committed");
  a_low_buffer: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_al) |=> $stable(compare_a_value))
    else $error("low write changed active value");
  a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
    on_rise |=> out_lvl == $past(output_initial_level))
    else $error("output not at initial level");
endmodule

/* File: hw/stm_pkg.sv */
package stm_pkg;
  // Register word offsets on the APB bus (byte addresses)
  localparam logic [7:0] ctrl0_off  = 8'h00;
  localparam logic [7:0] ctrl1_off  = 8'h04;
  localparam logic [7:0] cnt_lo_off = 8'h08;
  localparam logic [7:0] cnt_hi_off = 8'h0c;
  localparam logic [7:0] cmp_lo_off = 8'h10;
  localparam logic [7:0] cmp_hi_off = 8'h14;
  // Control zero fields
  localparam int pause_bit = 7;
  localparam int cksel_hi  = 6;
  localparam int cksel_lo  = 4;
  localparam int on_bit    = 3;
  localparam int per_hi    = 2;
  // Control one fields
  localparam int mode_hi   = 7;
  localparam int mode_lo   = 6;
  localparam int func_hi   = 5;
  localparam int func_lo   = 4;
  localparam int oc_bit    = 3;
  localparam int pol_bit   = 2;
  localparam int dpx_bit   = 1;
  localparam int cclr_bit  = 0;
  // Reset values
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [9:0] cnt_rst  = 10'h000;
  // Count width and period comparator width
  localparam int cnt_w = 10;
  localparam int per_w = 3;
  // Clock select codes
  localparam logic [2:0] ck_sys4 = 3'h0;
  localparam logic [2:0] ck_sys  = 3'h1;
  localparam logic [2:0] ck_h16  = 3'h2;
  localparam logic [2:0] ck_h64  = 3'h3;
  localparam logic [2:0] ck_tbc  = 3'h4;
  localparam logic [2:0] ck_rise = 3'h6;
  localparam logic [2:0] ck_fall = 3'h7;
  // Divider terminal counts (sys/4, high/16, high/64)
  localparam logic [5:0] div4_last  = 6'h03;
  localparam logic [5:0] div16_last = 6'h0f;
  localparam logic [5:0] div64_last = 6'h3f;
  // Modes
  localparam logic [1:0] md_cmp = 2'h0;
  localparam logic [1:0] md_cap = 2'h1;
  localparam logic [1:0] md_pwm = 2'h2;
  localparam logic [1:0] md_tmr = 2'h3;
  // Function codes
  localparam logic [1:0] fn_0 = 2'h0;
  localparam logic [1:0] fn_1 = 2'h1;
  localparam logic [1:0] fn_2 = 2'h2;
  localparam logic [1:0] fn_3 = 2'h3;
endpackage

/* File: hw/stm_edge_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser with rise and fall pulses
module stm_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic meta;   // First stage, read only by sync
  logic sync;   // Second stage
  logic prev;   // Delayed copy for edges

  // Sync chain; edge logic reads the second stage and its delayed copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign rise = sync & ~prev;
  assign fall = ~sync & prev;
endmodule

/* File: bench/stm_pin_model.sv */
`timescale 1ns/1ps
// Far-side source for the external clock and capture pins
module stm_pin_model (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic       cap_sel,
  input  wire logic [3:0] num,
  output logic            ext_pin,
  output logic            cap_pin
);
  // pins taken as already routed to the timer by software
  // One process drives both lines; they idle low between bursts
  // Each pulse is four cycles low then four high, slow enough to sync
  initial begin
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        repeat (num) begin
          repeat (4) @(posedge pclk);
          if (cap_sel) cap_pin <= 1'b1;
          else ext_pin <= 1'b1;
          repeat (4) @(posedge pclk);
          if (cap_sel) cap_pin <= 1'b0;
          else ext_pin <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: bench/stm_timer_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the ten-bit timer
module stm_timer_bench;
  localparam logic [7:0] a_c0 = stm_pkg::ctrl0_off;
  localparam logic [7:0] a_c1 = stm_pkg::ctrl1_off;
  localparam logic [7:0] a_dh = stm_pkg::cnt_hi_off;
  localparam logic [7:0] a_ah = stm_pkg::cmp_hi_off;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        high_clock_tick, time_base_tick;
  logic        external_count_clock_pin, capture_input_pin;
  logic        primary_output_pin, secondary_output_pin;
  logic        cmp_a_irq, cmp_p_irq;
  logic        go, go_cap;   // Pin burst request
  logic [3:0]  go_num;       // Pulses per burst
  int          err_count, check_count;
  int          cyc, na, np, ta, pa, tp, pp;  // Irq counts and times

  stm_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .high_clock_tick,
    .time_base_tick, .external_count_clock_pin, .capture_input_pin,
    .primary_output_pin, .secondary_output_pin, .cmp_a_irq, .cmp_p_irq);
  stm_pin_model pins (.pclk, .go, .cap_sel(go_cap), .num(go_num),
    .ext_pin(external_count_clock_pin), .cap_pin(capture_input_pin));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Irqs sampled mid-cycle so the edge updates have landed
  always @(negedge pclk) begin
    cyc <= cyc + 1;
    if (cmp_a_irq === 1'b1) begin
      na <= na + 1;
      pa <= ta;
      ta <= cyc;
    end
    if (cmp_p_irq === 1'b1) begin
      np <= np + 1;
      pp <= tp;
      tp <= cyc;
    end
  end
  // Time-base tick every eighth cycle
  always @(posedge pclk) time_base_tick <= (cyc % 8 == 0);

  ////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer; data taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] hi, output logic [9:0] v);
    logic [31:0] h, l;
    apb(1'b0, hi, 8'h00, h);
    apb(1'b0, hi - 8'h04, 8'h00, l);
    v = {h[1:0], l[7:0]};
  endtask

  task automatic fire(input logic cap, input logic [3:0] num);
    go_cap <= cap;
    go_num <= num;
    go     <= 1'b1;
    @(posedge pclk);
    go     <= 1'b0;
  endtask

  // Bounded wait for k more pulses of one irq
  task automatic wait_irq(input logic p, input int k);
    int n0, i;
    n0 = p ? np : na;
    for (i = 0; i < 5000 && (p ? np : na) < n0 + k; i++)
      @(posedge pclk);
    if (i == 5000) begin
      err_count++;
      print_verdict();
    end
  endtask

  // Ticks in a 64-cycle window per clock select code
  function automatic logic [31:0] exp_ticks(input logic [2:0] c);
    case (c)
      3'h0: return 32'h10;
      3'h1: return 32'h40;
      3'h2: return 32'h4;
      3'h3: return 32'h1;
      3'h4: return 32'h8;
      3'h5: return 32'h0;
      default: return 32'h3;
    endcase
  endfunction

  // Two pin pulses seen by each capture edge choice
  function automatic logic [31:0] exp_cap(input logic [1:0] f);
    return (f == 2'h3) ? 32'h0 : (f == 2'h2) ? 32'h4 : 32'h2;
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [9:0]  v0, v1, cv;
    logic [2:0]  c;
    logic        o;
    int          i, n0;
    void'($urandom(32'hd801));
    {psel, penable, pwrite, go, go_cap, presetn} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    go_num = 4'h0;
    high_clock_tick = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped word included
    for (i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 8'h00, r);
      chk("reset value", r, 32'h0);
    end
    cv = 10'($urandom_range(300, 16));
    wr(stm_pkg::cmp_lo_off, cv[7:0]);
    rdc(a_ah, v0);
    chk("low write held", {22'h0, v0}, 32'h0);
    wr(stm_pkg::cmp_lo_off, cv[7:0]);
    wr(a_ah, {6'h00, cv[9:8]});
    rdc(a_ah, v0);
    chk("compare readback", {22'h0, v0}, {22'h0, cv});
    wr(stm_pkg::cnt_lo_off, 8'hff);
    wr(a_dh, 8'h03);
    rdc(a_dh, v0);
    chk("counter write", {22'h0, v0}, 32'h0);
    $display("register test done");
    wr(a_c1, 8'hc0);
    for (i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(a_c0, {1'b0, c, 1'b1, 3'h0});
      rdc(a_dh, v0);
      fire(1'b0, (c[2:1] == 2'h3) ? 4'h3 : 4'h0);
      repeat (57) @(posedge pclk);
      rdc(a_dh, v1);
      chk("ticks", {22'h0, v1 - v0}, exp_ticks(c));
    end
    $display("clock select test done");
    wr(a_c0, 8'h98);
    rdc(a_dh, v0);
    repeat (20) @(posedge pclk);
    rdc(a_dh, v1);
    chk("paused", {22'h0, v1}, {22'h0, v0});
    wr(a_c0, 8'h18);
    rdc(a_dh, v1);
    chk("resumed", {22'h0, v1}, {22'h0, v0 + 10'h2});
    wr(a_c0, 8'h10);
    rdc(a_dh, v0);
    repeat (20) @(posedge pclk);
    rdc(a_dh, v1);
    chk("off holds", {22'h0, v1}, {22'h0, v0});
    wr(a_c0, 8'h18);
    rdc(a_dh, v1);
    chk("on clears", {22'h0, v1}, 32'h1);
    $display("run control test done");
    for (i = 0; i < 3; i++) begin
      c = (i == 0) ? 3'h1 : (i == 1) ? 3'($urandom_range(7, 2)) : 3'h0;
      wr(a_c0, {5'h03, c});
      wait_irq(1'b1, 3);
      chk("period", 32'(tp - pp), (c == 3'h0) ? 32'h400 :
          {22'h0, c, 7'h00});
    end
    $display("period test done");
    wr(a_c0, 8'h10);
    wr(a_c1, 8'h31);
    wr(a_c0, 8'h18);
    wait_irq(1'b0, 3);
    chk("compare period", 32'(ta - pa), {22'h0, cv + 10'h001});
    @(negedge pclk);
    o = primary_output_pin;
    wait_irq(1'b0, 1);
    @(negedge pclk);
    chk("toggle", {31'h0, primary_output_pin}, {31'h0, ~o});
    for (i = 0; i < 4; i++) begin
      wr(a_c0, 8'h10);
      wr(a_c1, {4'h0, i[0], i[1], 2'h1});
      wr(a_c0, 8'h18);
      // Level is loaded one edge after the on bit lands
      repeat (2) @(negedge pclk);
      chk("initial level", {30'h0, secondary_output_pin,
          primary_output_pin}, {30'h0, ~(i[0] ^ i[1]), i[0] ^ i[1]});
    end
    $display("output test done");
    for (i = 0; i < 4; i++) begin
      wr(a_c0, 8'h10);
      wr(a_c1, {2'h1, i[1:0], 4'h0});
      wr(a_c0, 8'h18);
      n0 = na;
      fire(1'b1, 4'h2);
      repeat (30) @(posedge pclk);
      chk("captures", 32'(na - n0), exp_cap(i[1:0]));
    end
    $display("capture test done");
    // PWM, period 128 from the period field, duty from compare A
    cv = 10'($urandom_range(100, 16));
    wr(a_c0, 8'h10);
    wr(stm_pkg::cmp_lo_off, cv[7:0]);
    wr(a_ah, 8'h00);
    wr(a_c1, 8'ha8);
    wr(a_c0, 8'h19);
    repeat (200) @(posedge pclk);
    n0 = 0;
    for (i = 0; i < 128; i++) begin
      @(negedge pclk);
      if (primary_output_pin === 1'b1) n0++;
    end
    chk("pwm high cycles", 32'(n0), {22'h0, cv + 10'h001});
    $display("pwm test done");
    print_verdict();
  end
endmodule
